// ---- src/qb_sram_end.sv ----
// qb_sram_end: memory end of the burst-of-four port: burst sequencing, arbitration, forwarding, dll model
// assumes pins are synchronous to core_clk and the controller toggles k every core_clk
`timescale 1ns/10ps
`include "qb_cfg.svh"
module qb_sram_end
    import qb_pkg::*;
#(
    parameter int DW = 18,
    parameter int BW = 2,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // pins
    qb_if.mem pins,
    // status
    output logic dll_locked,
    output logic zq_cal
);
    localparam int LW = DW / BW;
    localparam int RW = `QB_BURST * DW;
    localparam int RL = `QB_BURST * BW;

    logic k_q_r, kn_q_r, c_q_r, cn_q_r;
    logic single_r, single_nxt, strap_r, strap_nxt;
    qb_port_e last_r, last_nxt;
    logic racc_v_r, racc_v_nxt, arm_v_r, arm_v_nxt;
    logic [AW-1:0] racc_a_r, racc_a_nxt, arm_a_r, arm_a_nxt, act_a_r, act_a_nxt;
    logic [2:0] act_cnt_r, act_cnt_nxt;
    logic [DW-1:0] q_r, q_nxt;
    logic q_oe_r, q_oe_nxt, cq_r, cq_nxt, cqn_r, cqn_nxt;
    logic wacc_v_r, wacc_v_nxt, wact_v_r, wact_v_nxt;
    logic [AW-1:0] wacc_a_r, wacc_a_nxt, wact_a_r, wact_a_nxt;
    logic [1:0] widx_r, widx_nxt, cidx;
    logic [RW-1:0] wb_d_r, wb_d_nxt;
    logic [RL-1:0] wb_m_r, wb_m_nxt;
    qb_cnt_t lock_cnt_r, lock_cnt_nxt, stop_cnt_r, stop_cnt_nxt, zq_cnt_r, zq_cnt_nxt;
    logic locked_r, locked_nxt, zq_cal_r, zq_cal_nxt;

    logic k_rise, kn_rise, oc_rise, ocn_rise, k_still;
    logic rd_go, wr_go, wstart, wcap, commit, emit_busy;
    logic [AW-1:0] emit_a;
    logic [1:0] emit_j;
    logic [RW-1:0] row;
    logic [DW-1:0] fwd;

    // edges of the input and output clock pairs
    assign k_rise = pins.k & ~k_q_r;
    assign kn_rise = pins.k_n & ~kn_q_r;
    assign oc_rise = single_r ? k_rise : (pins.c & ~c_q_r);
    assign ocn_rise = single_r ? kn_rise : (pins.c_n & ~cn_q_r);
    assign k_still = (pins.k == k_q_r);

    // selects only count at k rise; same port on consecutive rises is dropped
    assign rd_go = k_rise & ~pins.read_port_select_n & (last_r != QB_RD);
    assign wr_go = k_rise & ~pins.write_port_select_n & (last_r != QB_WR) & ~rd_go;

    assign wstart = k_rise & wacc_v_r;
    assign wcap = wact_v_r & (k_rise | kn_rise);
    assign cidx = wstart ? 2'h0 : widx_r;
    assign commit = ~wstart & wcap & (widx_r == 2'(`QB_BURST - 1));

    assign emit_busy = (act_cnt_r != 3'h0);
    assign emit_a = emit_busy ? act_a_r : arm_a_r;
    assign emit_j = emit_busy ? 2'(`QB_BURST - act_cnt_r) : 2'h0;

    qb_store #(.DW(DW), .BW(BW), .AW(AW)) u_store (
        .core_clk(core_clk),
        .wr_en(commit),
        .wr_addr(wact_a_r),
        .wr_data(wb_d_nxt),
        .wr_lane(wb_m_nxt),
        .rd_addr(emit_a),
        .rd_data(row)
    );

    // lanes already captured by an open write to the same row win over the array
    always_comb begin
        fwd = row[emit_j*DW +: DW];
        for (int l = 0; l < BW; l++) begin
            if (wact_v_r && wact_a_r == emit_a && wb_m_r[emit_j*BW + l]) begin
                fwd[l*LW +: LW] = wb_d_r[emit_j*DW + l*LW +: LW];
            end
        end
    end

    // read and write sequencing
    always_comb begin
        last_nxt = last_r;
        racc_v_nxt = racc_v_r;
        racc_a_nxt = racc_a_r;
        arm_v_nxt = arm_v_r;
        arm_a_nxt = arm_a_r;
        act_a_nxt = act_a_r;
        act_cnt_nxt = act_cnt_r;
        q_nxt = q_r;
        q_oe_nxt = q_oe_r;
        wacc_v_nxt = wacc_v_r;
        wacc_a_nxt = wacc_a_r;
        wact_v_nxt = wact_v_r;
        wact_a_nxt = wact_a_r;
        widx_nxt = widx_r;
        wb_d_nxt = wb_d_r;
        wb_m_nxt = wb_m_r;
        if (oc_rise | ocn_rise) begin
            if (emit_busy) begin
                q_nxt = fwd;
                q_oe_nxt = 1'b1;
                act_cnt_nxt = act_cnt_r - 3'h1;
            end else if (arm_v_r) begin
                q_nxt = fwd;
                q_oe_nxt = 1'b1;
                act_a_nxt = arm_a_r;
                act_cnt_nxt = 3'(`QB_BURST - 1);
                arm_v_nxt = 1'b0;
            end else if (oc_rise) begin
                q_oe_nxt = 1'b0;
            end
        end
        if (k_rise) begin
            last_nxt = rd_go ? QB_RD : (wr_go ? QB_WR : QB_IDLE);
            racc_v_nxt = rd_go;
            if (rd_go) begin
                racc_a_nxt = pins.addr;
            end
            if (racc_v_r) begin
                arm_v_nxt = 1'b1;
                arm_a_nxt = racc_a_r;
            end
            wacc_v_nxt = wr_go;
            if (wr_go) begin
                wacc_a_nxt = pins.addr;
            end
        end
        if (wstart) begin
            wact_v_nxt = 1'b1;
            wact_a_nxt = wacc_a_r;
            wb_m_nxt = '0;
        end
        if (wstart | wcap) begin
            wb_d_nxt[cidx*DW +: DW] = pins.d;
            wb_m_nxt[cidx*BW +: BW] = ~pins.byte_write_select_n;
            widx_nxt = cidx + 2'h1;
        end
        if (commit) begin
            wact_v_nxt = 1'b0;
        end
    end

    // dll lock, impedance timer, echo clocks, single clock strap
    always_comb begin
        single_nxt = single_r;
        strap_nxt = 1'b1;
        if (!strap_r) begin
            single_nxt = pins.c & pins.c_n;
        end
        stop_cnt_nxt = k_still ? stop_cnt_r + qb_cnt_t'(1) : '0;
        lock_cnt_nxt = lock_cnt_r;
        if (k_still && stop_cnt_nxt >= qb_cnt_t'(`QB_DLL_STOP_CYC)) begin
            stop_cnt_nxt = qb_cnt_t'(`QB_DLL_STOP_CYC);
            lock_cnt_nxt = '0;
        end else if (k_rise && lock_cnt_r != qb_cnt_t'(`QB_DLL_LOCK_CYC)) begin
            lock_cnt_nxt = lock_cnt_r + qb_cnt_t'(1);
        end
        // with the dll off the lock flag stays low; data timing is unchanged in this model
        locked_nxt = pins.dll_off_n & (lock_cnt_nxt == qb_cnt_t'(`QB_DLL_LOCK_CYC));
        zq_cnt_nxt = zq_cnt_r;
        zq_cal_nxt = 1'b0;
        if (k_rise) begin
            if (zq_cnt_r == qb_cnt_t'(`QB_ZQ_CYC - 1)) begin
                zq_cnt_nxt = '0;
                zq_cal_nxt = 1'b1;
            end else begin
                zq_cnt_nxt = zq_cnt_r + qb_cnt_t'(1);
            end
        end
        cq_nxt = single_r ? pins.k : pins.c;
        cqn_nxt = single_r ? pins.k_n : pins.c_n;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            k_q_r <= 1'b0;
            kn_q_r <= 1'b0;
            c_q_r <= 1'b0;
            cn_q_r <= 1'b0;
            single_r <= 1'b0;
            strap_r <= 1'b0;
            last_r <= QB_IDLE;
            racc_v_r <= 1'b0;
            racc_a_r <= '0;
            arm_v_r <= 1'b0;
            arm_a_r <= '0;
            act_a_r <= '0;
            act_cnt_r <= 3'h0;
            q_r <= '0;
            q_oe_r <= 1'b0;
            wacc_v_r <= 1'b0;
            wacc_a_r <= '0;
            wact_v_r <= 1'b0;
            wact_a_r <= '0;
            widx_r <= 2'h0;
            wb_d_r <= '0;
            wb_m_r <= '0;
            lock_cnt_r <= '0;
            stop_cnt_r <= '0;
            locked_r <= 1'b0;
            zq_cnt_r <= '0;
            zq_cal_r <= 1'b0;
            cq_r <= 1'b0;
            cqn_r <= 1'b0;
        end else begin
            k_q_r <= pins.k;
            kn_q_r <= pins.k_n;
            c_q_r <= pins.c;
            cn_q_r <= pins.c_n;
            single_r <= single_nxt;
            strap_r <= strap_nxt;
            last_r <= last_nxt;
            racc_v_r <= racc_v_nxt;
            racc_a_r <= racc_a_nxt;
            arm_v_r <= arm_v_nxt;
            arm_a_r <= arm_a_nxt;
            act_a_r <= act_a_nxt;
            act_cnt_r <= act_cnt_nxt;
            q_r <= q_nxt;
            q_oe_r <= q_oe_nxt;
            wacc_v_r <= wacc_v_nxt;
            wacc_a_r <= wacc_a_nxt;
            wact_v_r <= wact_v_nxt;
            wact_a_r <= wact_a_nxt;
            widx_r <= widx_nxt;
            wb_d_r <= wb_d_nxt;
            wb_m_r <= wb_m_nxt;
            lock_cnt_r <= lock_cnt_nxt;
            stop_cnt_r <= stop_cnt_nxt;
            locked_r <= locked_nxt;
            zq_cnt_r <= zq_cnt_nxt;
            zq_cal_r <= zq_cal_nxt;
            cq_r <= cq_nxt;
            cqn_r <= cqn_nxt;
        end
    end

    assign pins.q = q_r;
    assign pins.q_oe = q_oe_r;
    assign pins.echo_clock = cq_r;
    assign pins.echo_clock_n = cqn_r;
    assign dll_locked = locked_r;
    assign zq_cal = zq_cal_r;
endmodule : qb_sram_end

// ---- src/qb_cfg.svh ----
// qb_cfg.svh: timing, burst and counter constants shared by both ends of the burst-of-four sram port
// assumes inclusion by bare name; one core_clk period stands for one half of the input clock pair
`ifndef QB_CFG_SVH
`define QB_CFG_SVH
`define QB_BURST 4
`define QB_CLK_NS 100
`define QB_DLL_STOP_NS 30
`define QB_DLL_STOP_CYC ((`QB_DLL_STOP_NS + `QB_CLK_NS - 1) / `QB_CLK_NS)
`define QB_DLL_LOCK_CYC 1024
`define QB_ZQ_CYC 1024
`define QB_CNT_W 11
`define QB_RD_TAP0 4
`define QB_RSR_W 8
`define QB_WSR_W 5
`endif

// ---- src/qb_pkg.sv ----
// qb_pkg: types of the burst-of-four sram port
// assumes qb_cfg.svh is on the include path
`include "qb_cfg.svh"
package qb_pkg;
    typedef enum logic [1:0] {QB_IDLE, QB_RD, QB_WR} qb_port_e;
    typedef logic [`QB_CNT_W-1:0] qb_cnt_t;
endpackage : qb_pkg

// ---- src/qb_if.sv ----
// qb_if: pins between memory controller and sram port
// assumes both ends share core_clk; q_oe low means q floats
`timescale 1ns/10ps
interface qb_if #(
    parameter int DW = 18,
    parameter int BW = 2,
    parameter int AW = 4
);
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic [AW-1:0] addr;
    logic read_port_select_n;
    logic write_port_select_n;
    logic [DW-1:0] d;
    logic [BW-1:0] byte_write_select_n;
    logic [DW-1:0] q;
    logic q_oe;
    logic echo_clock;
    logic echo_clock_n;
    logic dll_off_n;
    modport mem (
        input k, k_n, c, c_n, addr, read_port_select_n, write_port_select_n, d, byte_write_select_n, dll_off_n,
        output q, q_oe, echo_clock, echo_clock_n
    );
    modport ctl (
        output k, k_n, c, c_n, addr, read_port_select_n, write_port_select_n, d, byte_write_select_n, dll_off_n,
        input q, q_oe, echo_clock, echo_clock_n
    );
endinterface : qb_if

// ---- src/qb_store.sv ----
// qb_store: flip-flop array, one row of four words per address, lane-masked commit
// assumes the caller holds rd_addr steady for the fetch it wants; fetch is combinational
`timescale 1ns/10ps
`include "qb_cfg.svh"
module qb_store #(
    parameter int DW = 18,
    parameter int BW = 2,
    parameter int AW = 4
) (
    // clock
    input wire logic core_clk,
    // commit side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [`QB_BURST*DW-1:0] wr_data,
    input wire logic [`QB_BURST*BW-1:0] wr_lane,
    // fetch side
    input wire logic [AW-1:0] rd_addr,
    output logic [`QB_BURST*DW-1:0] rd_data
);
    localparam int LW = DW / BW;
    localparam int RL = `QB_BURST * BW;
    logic [`QB_BURST*DW-1:0] row [2**AW];

    for (genvar e = 0; e < 2**AW; e++) begin : g_row
        always_ff @(posedge core_clk) begin
            if (wr_en && wr_addr == AW'(e)) begin
                for (int l = 0; l < RL; l++) begin
                    if (wr_lane[l]) begin
                        row[e][l*LW +: LW] <= wr_data[l*LW +: LW];
                    end
                end
            end
        end
    end

    assign rd_data = row[rd_addr];
endmodule : qb_store

// ---- src/qb_ctrl_end.sv ----
// qb_ctrl_end: controller end: makes the clock pairs, issues one request per k rise, moves burst data
// assumes the memory end reads its pins on the same core_clk; read data lands four cycles after issue
`timescale 1ns/10ps
`include "qb_cfg.svh"
module qb_ctrl_end
    import qb_pkg::*;
#(
    parameter int DW = 18,
    parameter int BW = 2,
    parameter int AW = 4,
    parameter bit SINGLE_CLK = 1'b0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // pins
    qb_if.ctl pins,
    // command
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [AW-1:0] cmd_addr,
    input wire logic [`QB_BURST*DW-1:0] cmd_wdata,
    input wire logic [`QB_BURST*BW-1:0] cmd_lane,
    output logic cmd_ready,
    // read answer
    output logic rd_valid,
    output logic [`QB_BURST*DW-1:0] rd_data,
    // dll control
    input wire logic clk_hold,
    input wire logic dll_disable
);
    localparam int RW = `QB_BURST * DW;
    localparam int RL = `QB_BURST * BW;
    localparam int WS = `QB_WSR_W;
    localparam int RS = `QB_RSR_W;

    logic k_r, k_nxt, kn_r, kn_nxt, c_r, c_nxt, cn_r, cn_nxt, dll_off_n_r, dll_off_n_nxt;
    qb_cnt_t lock_cnt_r, lock_cnt_nxt;
    logic locked_r, locked_nxt, ready_r, ready_nxt;
    qb_port_e last_r, last_nxt;
    logic hold_v_r, hold_v_nxt, hold_w_r, hold_w_nxt;
    logic [AW-1:0] hold_a_r, hold_a_nxt, addr_r, addr_nxt;
    logic [RW-1:0] hold_d_r, hold_d_nxt, rbuf_r, rbuf_nxt, rd_data_r, rd_data_nxt;
    logic [RL-1:0] hold_l_r, hold_l_nxt;
    logic rps_r, rps_nxt, wps_r, wps_nxt, rd_valid_r, rd_valid_nxt;
    logic [DW-1:0] d_r, d_nxt;
    logic [BW-1:0] bws_r, bws_nxt;
    logic wslot_r, wslot_nxt;
    logic [RW-1:0] wd_r [2];
    logic [RW-1:0] wd_nxt [2];
    logic [RL-1:0] wl_r [2];
    logic [RL-1:0] wl_nxt [2];
    logic [WS-1:0] wsr_r, wsr_nxt, wtag_r, wtag_nxt;
    logic [RS-1:0] rsr_r, rsr_nxt;
    logic rise_next, may_go, go_rd, go_wr;

    assign rise_next = ~k_r & ~clk_hold;
    assign may_go = rise_next & hold_v_r & (locked_r | ~dll_off_n_r);
    assign go_rd = may_go & ~hold_w_r & (last_r != QB_RD);
    assign go_wr = may_go & hold_w_r & (last_r != QB_WR);

    always_comb begin
        k_nxt = clk_hold ? k_r : ~k_r;
        kn_nxt = ~k_nxt;
        c_nxt = SINGLE_CLK | k_nxt;
        cn_nxt = SINGLE_CLK | kn_nxt;
        dll_off_n_nxt = ~dll_disable;
        lock_cnt_nxt = lock_cnt_r;
        if (clk_hold) begin
            lock_cnt_nxt = '0;
        end else if (rise_next && lock_cnt_r != qb_cnt_t'(`QB_DLL_LOCK_CYC)) begin
            lock_cnt_nxt = lock_cnt_r + qb_cnt_t'(1);
        end
        locked_nxt = (lock_cnt_nxt == qb_cnt_t'(`QB_DLL_LOCK_CYC));
        last_nxt = last_r;
        if (rise_next) begin
            last_nxt = go_rd ? QB_RD : (go_wr ? QB_WR : QB_IDLE);
        end
        rps_nxt = ~go_rd;
        wps_nxt = ~go_wr;
        addr_nxt = (go_rd | go_wr) ? hold_a_r : addr_r;
        hold_v_nxt = hold_v_r & ~(go_rd | go_wr);
        hold_w_nxt = hold_w_r;
        hold_a_nxt = hold_a_r;
        hold_d_nxt = hold_d_r;
        hold_l_nxt = hold_l_r;
        if (cmd_valid && ready_r) begin
            hold_v_nxt = 1'b1;
            hold_w_nxt = cmd_write;
            hold_a_nxt = cmd_addr;
            hold_d_nxt = cmd_wdata;
            hold_l_nxt = cmd_lane;
        end
        ready_nxt = ~hold_v_nxt;
        // two slots so a write issued four cycles later cannot clobber words still going out
        wd_nxt = wd_r;
        wl_nxt = wl_r;
        wslot_nxt = wslot_r;
        if (go_wr) begin
            wd_nxt[wslot_r] = hold_d_r;
            wl_nxt[wslot_r] = hold_l_r;
            wslot_nxt = ~wslot_r;
        end
        wsr_nxt = {wsr_r[WS-2:0], go_wr};
        wtag_nxt = {wtag_r[WS-2:0], wslot_r};
        d_nxt = d_r;
        bws_nxt = '1;
        for (int i = 1; i < WS; i++) begin
            if (wsr_r[i]) begin
                d_nxt = wd_r[wtag_r[i]][(i-1)*DW +: DW];
                bws_nxt = ~wl_r[wtag_r[i]][(i-1)*BW +: BW];
            end
        end
        rsr_nxt = {rsr_r[RS-2:0], go_rd};
        rbuf_nxt = rbuf_r;
        for (int i = `QB_RD_TAP0; i < RS; i++) begin
            if (rsr_r[i]) begin
                rbuf_nxt[(i-`QB_RD_TAP0)*DW +: DW] = pins.q;
            end
        end
        rd_valid_nxt = rsr_r[RS-1];
        rd_data_nxt = rsr_r[RS-1] ? rbuf_nxt : rd_data_r;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            k_r <= 1'b0;
            kn_r <= 1'b1;
            c_r <= SINGLE_CLK;
            cn_r <= 1'b1;
            dll_off_n_r <= 1'b1;
            lock_cnt_r <= '0;
            locked_r <= 1'b0;
            ready_r <= 1'b0;
            last_r <= QB_IDLE;
            hold_v_r <= 1'b0;
            hold_w_r <= 1'b0;
            hold_a_r <= '0;
            hold_d_r <= '0;
            hold_l_r <= '0;
            addr_r <= '0;
            rps_r <= 1'b1;
            wps_r <= 1'b1;
            d_r <= '0;
            bws_r <= '1;
            wslot_r <= 1'b0;
            wd_r <= '{default: '0};
            wl_r <= '{default: '0};
            wsr_r <= '0;
            wtag_r <= '0;
            rsr_r <= '0;
            rbuf_r <= '0;
            rd_valid_r <= 1'b0;
            rd_data_r <= '0;
        end else begin
            k_r <= k_nxt;
            kn_r <= kn_nxt;
            c_r <= c_nxt;
            cn_r <= cn_nxt;
            dll_off_n_r <= dll_off_n_nxt;
            lock_cnt_r <= lock_cnt_nxt;
            locked_r <= locked_nxt;
            ready_r <= ready_nxt;
            last_r <= last_nxt;
            hold_v_r <= hold_v_nxt;
            hold_w_r <= hold_w_nxt;
            hold_a_r <= hold_a_nxt;
            hold_d_r <= hold_d_nxt;
            hold_l_r <= hold_l_nxt;
            addr_r <= addr_nxt;
            rps_r <= rps_nxt;
            wps_r <= wps_nxt;
            d_r <= d_nxt;
            bws_r <= bws_nxt;
            wslot_r <= wslot_nxt;
            wd_r <= wd_nxt;
            wl_r <= wl_nxt;
            wsr_r <= wsr_nxt;
            wtag_r <= wtag_nxt;
            rsr_r <= rsr_nxt;
            rbuf_r <= rbuf_nxt;
            rd_valid_r <= rd_valid_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign pins.k = k_r;
    assign pins.k_n = kn_r;
    assign pins.c = c_r;
    assign pins.c_n = cn_r;
    assign pins.addr = addr_r;
    assign pins.read_port_select_n = rps_r;
    assign pins.write_port_select_n = wps_r;
    assign pins.d = d_r;
    assign pins.byte_write_select_n = bws_r;
    assign pins.dll_off_n = dll_off_n_r;
    assign cmd_ready = ready_r;
    assign rd_valid = rd_valid_r;
    assign rd_data = rd_data_r;
endmodule : qb_ctrl_end

// ---- test/qb_port_monitor.sv ----
// qb_port_monitor: concurrent checks on the pins between the two ends of the burst port
// assumes one core_clk for both ends and a controller that toggles k every cycle
`timescale 1ns/10ps
module qb_port_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // pins
    input wire logic k,
    input wire logic c,
    input wire logic c_n,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic q_oe,
    input wire logic echo_clock,
    input wire logic echo_clock_n,
    input wire logic dll_off_n,
    // status
    input wire logic dll_locked,
    input wire logic zq_cal
);
    logic k_r, k_nxt, k_rise, seen_r, seen_nxt;
    logic rd_req, wr_req;
    logic [10:0] zq_r, zq_nxt;
    logic [11:0] st_r, st_nxt;
    always_comb begin
        k_nxt = k;
        k_rise = k & ~k_r;
        // plain flags so the spacing checks can negate a request
        rd_req = k_rise & ~read_port_select_n;
        wr_req = k_rise & ~write_port_select_n;
        seen_nxt = seen_r | zq_cal;
        zq_nxt = zq_cal ? 11'h0 : zq_r + {10'h0, k_rise};
        // a held k restarts the lock count; saturates so it never wraps
        st_nxt = (k == k_r) ? 12'h0 : st_r + {11'h0, k_rise & ~&st_r};
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            k_r <= 1'b0;
            seen_r <= 1'b0;
            zq_r <= 11'h0;
            st_r <= 12'h0;
        end else begin
            k_r <= k_nxt;
            seen_r <= seen_nxt;
            zq_r <= zq_nxt;
            st_r <= st_nxt;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence rd_start;
        rd_req;
    endsequence
    sequence wr_start;
        wr_req;
    endsequence
    rd_burst_a: assert property (rd_start |-> ##4 q_oe [*4])
        else $error("read burst not driven");
    rd_float_a: assert property (rd_start ##4 !rd_req |-> ##5 !q_oe)
        else $error("q not floated after burst");
    reset_quiet_a: assert property ($fell(sys_rst) |-> !q_oe && read_port_select_n && write_port_select_n)
        else $error("not quiet after reset");
    echo_follow_a: assert property (!$past(sys_rst) |-> echo_clock == $past(c) && echo_clock_n == $past(c_n))
        else $error("echo clock off output clock");
    rd_space_a: assert property (rd_start |-> ##2 !rd_req)
        else $error("reads on consecutive k rises");
    wr_space_a: assert property (wr_start |-> ##2 !wr_req)
        else $error("writes on consecutive k rises");
    zq_period_a: assert property (zq_cal && seen_r |-> zq_r + k_rise == 11'h400)
        else $error("recalibration period wrong");
    dll_lock_a: assert property ($rose(dll_locked) |-> st_r >= 12'h400 && dll_off_n)
        else $error("lock too early");
    dll_late_a: assert property (st_r >= 12'h402 && dll_off_n && $past(dll_off_n) |-> dll_locked)
        else $error("lock missing");
    dll_stop_a: assert property (k == k_r |-> ##[1:2] !dll_locked)
        else $error("lock kept over stopped clock");
    dll_off_a: assert property (!dll_off_n |=> !dll_locked)
        else $error("lock shown with dll off");
endmodule : qb_port_monitor

// ---- test/quad_rate_burst4_sram_port_tb_top.sv ----
// quad_rate_burst4_sram_port_tb_top: both ends joined by qb_if, commands in, read data checked
// assumes default widths; the memory array is unreset, so every row is written before reads
`timescale 1ns/10ps
module quad_rate_burst4_sram_port_tb_top;
    localparam int DW = 18;
    localparam int BW = 2;
    localparam int AW = 4;
    localparam int WW = 4 * DW;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [AW-1:0] cmd_addr = 4'h0;
    logic [WW-1:0] cmd_wdata = '0;
    logic [4*BW-1:0] cmd_lane = 8'h00;
    logic clk_hold = 1'b0;
    logic dll_disable = 1'b0;
    logic cmd_ready, rd_valid, dll_locked, zq_cal;
    logic rd_valid_s;
    logic [WW-1:0] rd_data, rd_data_s;
    logic [WW-1:0] mem [16];
    logic [WW-1:0] exp_q [$];
    logic [AW-1:0] a;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    qb_if #(.DW(DW), .BW(BW), .AW(AW)) i_qb_if ();
    qb_sram_end #(.DW(DW), .BW(BW), .AW(AW)) i_qb_sram_end (.core_clk(core_clk), .sys_rst(sys_rst),
        .pins(i_qb_if.mem), .dll_locked(dll_locked), .zq_cal(zq_cal));
    qb_ctrl_end #(.DW(DW), .BW(BW), .AW(AW), .SINGLE_CLK(1'b0)) i_qb_ctrl_end (.core_clk(core_clk),
        .sys_rst(sys_rst), .pins(i_qb_if.ctl), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_lane(cmd_lane), .cmd_ready(cmd_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .clk_hold(clk_hold), .dll_disable(dll_disable));
    qb_port_monitor i_qb_port_monitor (.core_clk(core_clk), .sys_rst(sys_rst), .k(i_qb_if.k), .c(i_qb_if.c),
        .c_n(i_qb_if.c_n), .read_port_select_n(i_qb_if.read_port_select_n),
        .write_port_select_n(i_qb_if.write_port_select_n), .q_oe(i_qb_if.q_oe),
        .echo_clock(i_qb_if.echo_clock), .echo_clock_n(i_qb_if.echo_clock_n),
        .dll_off_n(i_qb_if.dll_off_n), .dll_locked(dll_locked), .zq_cal(zq_cal));
    // second pair on the single clock strap: c pair held high, the memory end times read data and echo clocks from k
    qb_if #(.DW(DW), .BW(BW), .AW(AW)) i_qb_if_s ();
    qb_sram_end #(.DW(DW), .BW(BW), .AW(AW)) i_qb_sram_end_s (.core_clk(core_clk), .sys_rst(sys_rst),
        .pins(i_qb_if_s.mem), .dll_locked(), .zq_cal());
    qb_ctrl_end #(.DW(DW), .BW(BW), .AW(AW), .SINGLE_CLK(1'b1)) i_qb_ctrl_end_s (.core_clk(core_clk),
        .sys_rst(sys_rst), .pins(i_qb_if_s.ctl), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_lane(cmd_lane), .cmd_ready(),
        .rd_valid(rd_valid_s), .rd_data(rd_data_s), .clk_hold(clk_hold), .dll_disable(dll_disable));
    always #50 core_clk = ~core_clk;
    task automatic check(input logic [WW-1:0] seen, input logic [WW-1:0] expct);
        check_count++;
        if (seen !== expct) begin
            n_mismatch++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, expct);
        end
    endtask : check
    task automatic results();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    function automatic logic [WW-1:0] rnd();
        return WW'({$urandom(), $urandom(), $urandom()});
    endfunction : rnd
    // model updated at hand-off; the controller issues in order, so notes line up with answers
    task automatic send(input logic wr, input logic [AW-1:0] ad, input logic [WW-1:0] wd, input logic [7:0] ln);
        @(negedge core_clk);
        while (cmd_ready !== 1'b1) @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = ad;
        cmd_wdata = wd;
        cmd_lane = ln;
        if (wr) begin
            for (int i = 0; i < 4 * BW; i++) if (ln[i]) mem[ad][i*9 +: 9] = wd[i*9 +: 9];
        end else begin
            exp_q.push_back(mem[ad]);
        end
        @(negedge core_clk);
        cmd_valid = 1'b0;
    endtask : send
    always @(negedge core_clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("[FAIL] %0t ns: read data with none pending", $time);
            end else begin
                check(WW'(rd_valid_s), WW'(1'b1));
                check(rd_data_s, exp_q[0]);
                check(rd_data, exp_q.pop_front());
            end
        end
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        void'($urandom(32'hf4c614a0));
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        @(negedge core_clk);
        check(WW'(i_qb_if.q_oe), WW'(1'b0));
        check(WW'(i_qb_if.read_port_select_n & i_qb_if.write_port_select_n), WW'(1'b1));
        for (int i = 0; i < 16; i++) send(1'b1, AW'(i), rnd(), 8'hff);
        check(WW'(dll_locked), WW'(1'b1));
        for (int i = 0; i < 80; i++) begin
            if (i == 40) begin
                // controller data pipes run on core_clk, not k: let bursts drain before stopping k
                while (cmd_ready !== 1'b1 || exp_q.size() != 0) @(negedge core_clk);
                repeat (12) @(negedge core_clk);
                clk_hold = 1'b1;
                repeat (3) @(negedge core_clk);
                clk_hold = 1'b0;
                repeat (2) @(negedge core_clk);
                check(WW'(dll_locked), WW'(1'b0));
            end
            // dll off lets traffic run without waiting for lock
            dll_disable = (i >= 60);
            a = AW'($urandom_range(15));
            send(1'($urandom()), a, rnd(), (i % 8 == 1) ? 8'h00 : 8'($urandom()));
            if (i % 3 == 0) send(1'b0, a, rnd(), 8'h00);
        end
        check(WW'(dll_locked), WW'(1'b0));
        for (int i = 0; i < 16; i++) send(1'b0, AW'(i), rnd(), 8'h00);
        while (exp_q.size() != 0) @(negedge core_clk);
        repeat (12) @(negedge core_clk);
        results();
    end
endmodule : quad_rate_burst4_sram_port_tb_top
